//--- hdl/crpa_pkg.sv
`default_nettype none
package crpa_pkg;
  // ---------------------------------------------------------------
  // I/O port addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] PORT_LO_IDX = 8'h70;
  localparam logic [7:0] PORT_LO_DAT = 8'h71;
  localparam logic [7:0] PORT_EXT_IDX = 8'h72;
  localparam logic [7:0] PORT_EXT_DAT = 8'h73;
  localparam logic [7:0] PORT_SR_IDX = 8'h74;
  localparam logic [7:0] PORT_SR_DAT = 8'h75;
  // Enable bit positions in the outside configuration registers; NMI disable bit of the lower index
  localparam int CLK_SEL_BIT = 2;
  localparam int SRAM_EN_BIT = 1;
  localparam int PORT_EN_BIT = 3;
  localparam int NMI_DIS_BIT = 7;
  localparam logic NMI_DIS_RESET = 1'b1;
  // ---------------------------------------------------------------
  // CMOS offsets of the clock registers
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_SEC = 8'h00;
  localparam logic [7:0] OFS_SEC_ALM = 8'h01;
  localparam logic [7:0] OFS_MIN = 8'h02;
  localparam logic [7:0] OFS_MIN_ALM = 8'h03;
  localparam logic [7:0] OFS_HOUR = 8'h04;
  localparam logic [7:0] OFS_HOUR_ALM = 8'h05;
  localparam logic [7:0] OFS_WDAY = 8'h06;
  localparam logic [7:0] OFS_DATE = 8'h07;
  localparam logic [7:0] OFS_MONTH = 8'h08;
  localparam logic [7:0] OFS_YEAR = 8'h09;
  localparam logic [7:0] OFS_CTL_A = 8'h0A;
  localparam logic [7:0] OFS_CTL_B = 8'h0B;
  localparam logic [7:0] OFS_FLAGS_C = 8'h0C;
  localparam logic [7:0] OFS_BATT_D = 8'h0D;
  localparam logic [7:0] OFS_DATE_ALM = 8'h7D;
  localparam logic [7:0] OFS_MONTH_ALM = 8'h7E;
  localparam logic [7:0] OFS_CENTURY = 8'h7F;
  // Control field values and positions
  localparam logic [2:0] DIV_RUN = 3'h2;
  localparam int B_SET = 7;
  localparam int B_BINARY = 2;
  localparam int B_24H = 1;
  localparam int HOUR_PM_BIT = 7;
  // Range limits, binary and BCD
  localparam logic [7:0] SEC_MAX_BIN = 8'h3B;
  localparam logic [7:0] SEC_MAX_BCD = 8'h59;
  localparam logic [7:0] H24_MAX_BIN = 8'h17;
  localparam logic [7:0] H24_MAX_BCD = 8'h23;
  localparam logic [7:0] H12_MAX_BIN = 8'h0C;
  localparam logic [7:0] H12_MAX_BCD = 8'h12;
  localparam logic [7:0] H12_PRE_BIN = 8'h0B;
  localparam logic [7:0] H12_PRE_BCD = 8'h11;
  localparam logic [7:0] WDAY_MAX = 8'h07;
  localparam logic [7:0] MON_MAX_BIN = 8'h0C;
  localparam logic [7:0] MON_MAX_BCD = 8'h12;
  localparam logic [7:0] YEAR_MAX_BIN = 8'h63;
  localparam logic [7:0] YEAR_MAX_BCD = 8'h99;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [7:0] ZERO = 8'h00;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SEC_TIME_S = 1;
  localparam int SEC_CYCLES_DEF = CLK_HZ * SEC_TIME_S;
  // Request forwarded to the outside clock chip
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crpa_ext_type;
endpackage : crpa_pkg
`default_nettype wire

//--- hdl/crpa_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Index bit 7 clear lets channel-check or system error raise NMI.
// - NMI disable bit is one after reset.
// - Lower index bits 6-0 are a write-only index into lower 128 bytes.
// - Lower data port reads and writes the indexed lower byte.
// - Lower pair served inside only when clock-select bit 2 is one, else forwarded.
// - Extended index is readable 8-bit, its data port reaches all 256 bytes.
// - Extended pair served inside only when clock-select bit 2 is one, else forwarded.
// - Third pair answers only when SRAM-enable bit 1 and port-enable bit 3 set.
// - Third pair reaches all 256 bytes even with the on-chip clock off.
// - Clock registers sit at 00-0D and 7D-7F, everything else is storage.
// - Time registers count in binary or BCD; 12-hour pm sets hour bit 7.
// - Control A: bit 7 update busy, bits 6-4 divider, 3-0 periodic rate.
// - Control B: bit 7 stops updates, bits 6-4 enable three interrupts.
// - Control B bit 3 is plain storage.
// - Control B bit 2 picks binary over BCD.
// - Control B bit 1 picks 24-hour, bit 0 is plain storage.
// - Status D bit 7 shows battery good, other bits read zero.
// - Offsets 80-FF are 128 bytes of plain storage.
module crpa_top
  import crpa_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYCLES_DEF,
  parameter int BUSY_CYCLES = 64,
  parameter int PER_BASE = 16
)(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [7:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  output logic IO_ACK,
  input wire logic [7:0] CLOCK_SELECT_REG,
  input wire logic [7:0] SRAM_ENABLE_REG,
  input wire logic [7:0] THIRD_PORT_ENABLE_REG,
  input wire logic ISA_CHCK_N,
  input wire logic PCI_SERR_N,
  input wire logic BATTERY_GOOD,
  output logic NMI,
  output var crpa_ext_type EXT_RTC
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Increment with wrap; returns {carry, next}
  function automatic logic [8:0] crpa_inc(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi, input logic bcd);
    logic [7:0] n;
    n = (bcd && v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + ONE;
    return (v == hi) ? {1'b1, lo} : {1'b0, n};
  endfunction : crpa_inc

  // Top value chosen by encoding
  function automatic logic [7:0] crpa_lim(input logic bcd, input logic [7:0] b, input logic [7:0] d);
    return bcd ? d : b;
  endfunction : crpa_lim

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] mem_reg [256];
  logic [6:0] lo_idx_reg;
  logic nmi_dis_reg;
  logic [7:0] ext_idx_reg;
  logic [7:0] sr_idx_reg;
  logic [31:0] sec_cnt_reg;
  logic [31:0] per_cnt_reg;
  logic busy_reg;
  logic upd_reg;
  logic [2:0] flags_reg;
  logic [2:0] flags_next;
  logic chk_s1_reg, chk_s2_reg, serr_s1_reg, serr_s2_reg, bat_s1_reg, bat_s2_reg;

  // ---------------------------------------------------------------
  // Port decode
  // ---------------------------------------------------------------
  wire logic acc = IO_WR | IO_RD;
  wire logic clk_int = CLOCK_SELECT_REG[CLK_SEL_BIT];
  wire logic sel_lo = (IO_ADDR == PORT_LO_IDX) || (IO_ADDR == PORT_LO_DAT);
  wire logic sel_ext = (IO_ADDR == PORT_EXT_IDX) || (IO_ADDR == PORT_EXT_DAT);
  wire logic sel_sr = (IO_ADDR == PORT_SR_IDX) || (IO_ADDR == PORT_SR_DAT);
  wire logic sr_open = SRAM_ENABLE_REG[SRAM_EN_BIT] & THIRD_PORT_ENABLE_REG[PORT_EN_BIT];
  wire logic int_hit = acc && (((sel_lo || sel_ext) && clk_int) || (sel_sr && sr_open));
  wire logic fwd_hit = acc && (sel_lo || sel_ext) && !clk_int;
  wire logic is_dat = (IO_ADDR == PORT_LO_DAT) || (IO_ADDR == PORT_EXT_DAT) || (IO_ADDR == PORT_SR_DAT);
  // Data-port target byte
  wire logic [7:0] cm_addr = (IO_ADDR == PORT_LO_DAT) ? {1'b0, lo_idx_reg} :
                             (IO_ADDR == PORT_EXT_DAT) ? ext_idx_reg : sr_idx_reg;
  wire logic dat_wr = IO_WR && int_hit && is_dat;
  wire logic dat_rd = IO_RD && int_hit && is_dat;
  wire logic c_read = dat_rd && (cm_addr == OFS_FLAGS_C);
  // Host writes land only on storage-backed bytes
  wire logic mem_wr = dat_wr && (cm_addr != OFS_FLAGS_C) && (cm_addr != OFS_BATT_D);

  // ---------------------------------------------------------------
  // Clock fields
  // ---------------------------------------------------------------
  wire logic [7:0] ctl_a = mem_reg[OFS_CTL_A];
  wire logic [7:0] ctl_b = mem_reg[OFS_CTL_B];
  wire logic bcd = !ctl_b[B_BINARY];
  wire logic run = (ctl_a[6:4] == DIV_RUN);
  wire logic tick = run && (sec_cnt_reg == 32'(SEC_CYCLES - 1));
  wire logic do_upd = tick && !ctl_b[B_SET];
  wire logic [3:0] rate = ctl_a[3:0];
  wire logic [31:0] per_len = 32'(PER_BASE) << rate;
  wire logic per_tick = run && (rate != 4'h0) && (per_cnt_reg >= per_len - 32'h1);
  wire logic [7:0] sec_max = crpa_lim(bcd, SEC_MAX_BIN, SEC_MAX_BCD);
  wire logic any_irq_flag = |(flags_reg & ctl_b[6:4]);

  // ---------------------------------------------------------------
  // Time rollover chain
  // ---------------------------------------------------------------
  // Binary and BCD share one incrementer; the limits and the decimal carry after 9 change
  wire logic [8:0] sec_n = crpa_inc(mem_reg[OFS_SEC], ZERO, sec_max, bcd);
  wire logic [8:0] min_n = crpa_inc(mem_reg[OFS_MIN], ZERO, sec_max, bcd);
  wire logic [7:0] hour = mem_reg[OFS_HOUR];
  wire logic h12_pre = ({1'b0, hour[6:0]} == crpa_lim(bcd, H12_PRE_BIN, H12_PRE_BCD));
  wire logic [8:0] h24_n = crpa_inc(hour, ZERO, crpa_lim(bcd, H24_MAX_BIN, H24_MAX_BCD), bcd);
  wire logic [8:0] h12_n = crpa_inc({1'b0, hour[6:0]}, ONE, crpa_lim(bcd, H12_MAX_BIN, H12_MAX_BCD), bcd);
  // 11 pm to 12 am carries into the date
  wire logic [8:0] hour_n = ctl_b[B_24H] ? h24_n :
                            {h12_pre & hour[HOUR_PM_BIT], hour[HOUR_PM_BIT] ^ h12_pre, h12_n[6:0]};
  wire logic [8:0] wday_n = crpa_inc(mem_reg[OFS_WDAY], ONE, WDAY_MAX, bcd);
  wire logic [7:0] mon = mem_reg[OFS_MONTH];
  wire logic mon_30 = bcd ? (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) :
                            (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h0B);
  // No leap-year tracking: February always ends on the 28th
  wire logic [7:0] dmax = (mon == 8'h02) ? crpa_lim(bcd, 8'h1C, 8'h28) :
                          mon_30 ? crpa_lim(bcd, 8'h1E, 8'h30) : crpa_lim(bcd, 8'h1F, 8'h31);
  wire logic [8:0] date_n = crpa_inc(mem_reg[OFS_DATE], ONE, dmax, bcd);
  wire logic [8:0] mon_n = crpa_inc(mon, ONE, crpa_lim(bcd, MON_MAX_BIN, MON_MAX_BCD), bcd);
  wire logic [8:0] year_n = crpa_inc(mem_reg[OFS_YEAR], ZERO, crpa_lim(bcd, YEAR_MAX_BIN, YEAR_MAX_BCD), bcd);
  wire logic c_min = sec_n[8];
  wire logic c_hour = c_min & min_n[8];
  wire logic c_day = c_hour & hour_n[8];
  wire logic c_mon = c_day & date_n[8];
  wire logic c_year = c_mon & mon_n[8];
  // Alarm compare on the freshly updated time
  wire logic alm_match = (mem_reg[OFS_SEC] == mem_reg[OFS_SEC_ALM]) && (mem_reg[OFS_MIN] == mem_reg[OFS_MIN_ALM])
    && (hour == mem_reg[OFS_HOUR_ALM]) && (mem_reg[OFS_DATE] == mem_reg[OFS_DATE_ALM])
    && (mon == mem_reg[OFS_MONTH_ALM]);

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  wire logic [7:0] cm_rd = (cm_addr == OFS_CTL_A) ? {busy_reg, ctl_a[6:0]} :
                           (cm_addr == OFS_FLAGS_C) ? {any_irq_flag, flags_reg, 4'h0} :
                           (cm_addr == OFS_BATT_D) ? {bat_s2_reg, 7'h00} :
                           mem_reg[cm_addr];
  // Lower index is write-only and reads back zero
  wire logic [7:0] rd_val = is_dat ? cm_rd : (IO_ADDR == PORT_EXT_IDX) ? ext_idx_reg :
                            (IO_ADDR == PORT_SR_IDX) ? sr_idx_reg : ZERO;

  // Set beats the read-clear
  assign flags_next = (flags_reg & {3{!c_read}}) | {per_tick, upd_reg & alm_match, upd_reg};

  // ---------------------------------------------------------------
  // Pin synchronisers and NMI
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      {chk_s1_reg, chk_s2_reg, serr_s1_reg, serr_s2_reg, bat_s1_reg, bat_s2_reg} <= 6'h00;
      NMI <= 1'b0;
    end
    else
    begin
      {chk_s1_reg, chk_s2_reg} <= {!ISA_CHCK_N, chk_s1_reg};
      {serr_s1_reg, serr_s2_reg} <= {!PCI_SERR_N, serr_s1_reg};
      {bat_s1_reg, bat_s2_reg} <= {BATTERY_GOOD, bat_s1_reg};
      NMI <= !nmi_dis_reg && (chk_s2_reg || serr_s2_reg);
    end
  end

  // ---------------------------------------------------------------
  // Index registers and host answer
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      lo_idx_reg <= 7'h00;
      nmi_dis_reg <= NMI_DIS_RESET;
      ext_idx_reg <= ZERO;
      sr_idx_reg <= ZERO;
      IO_RDATA <= ZERO;
      IO_ACK <= 1'b0;
      EXT_RTC <= '0;
    end
    else
    begin
      if (IO_WR && int_hit && IO_ADDR == PORT_LO_IDX)
        {nmi_dis_reg, lo_idx_reg} <= IO_WDATA;
      if (IO_WR && int_hit && IO_ADDR == PORT_EXT_IDX)
        ext_idx_reg <= IO_WDATA;
      if (IO_WR && int_hit && IO_ADDR == PORT_SR_IDX)
        sr_idx_reg <= IO_WDATA;
      IO_ACK <= int_hit;
      IO_RDATA <= (IO_RD && int_hit) ? rd_val : ZERO;
      EXT_RTC <= '{rd: IO_RD & fwd_hit, wr: IO_WR & fwd_hit, addr: IO_ADDR, wdata: IO_WDATA};
    end
  end

  // ---------------------------------------------------------------
  // Dividers, update and flags
  // ---------------------------------------------------------------
  // Divider held at zero while stopped so a restart begins a full second
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sec_cnt_reg <= 32'h0;
      per_cnt_reg <= 32'h0;
      busy_reg <= 1'b0;
      upd_reg <= 1'b0;
      flags_reg <= 3'h0;
    end
    else
    begin
      sec_cnt_reg <= (!run || tick) ? 32'h0 : sec_cnt_reg + 32'h1;
      per_cnt_reg <= (!run || per_tick) ? 32'h0 : per_cnt_reg + 32'h1;
      busy_reg <= run && !ctl_b[B_SET] && (sec_cnt_reg >= 32'(SEC_CYCLES - BUSY_CYCLES));
      upd_reg <= do_upd;
      flags_reg <= flags_next;
    end
  end

  // ---------------------------------------------------------------
  // CMOS array
  // ---------------------------------------------------------------
  // Host write comes last so it overrides a same-cycle update
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int i = 0; i < 256; i++)
        mem_reg[i] <= ZERO;
    end
    else
    begin
      if (do_upd)
      begin
        mem_reg[OFS_SEC] <= sec_n[7:0];
        if (c_min) mem_reg[OFS_MIN] <= min_n[7:0];
        if (c_hour) mem_reg[OFS_HOUR] <= hour_n[7:0];
        if (c_day) mem_reg[OFS_WDAY] <= wday_n[7:0];
        if (c_day) mem_reg[OFS_DATE] <= date_n[7:0];
        if (c_mon) mem_reg[OFS_MONTH] <= mon_n[7:0];
        if (c_year) mem_reg[OFS_YEAR] <= year_n[7:0];
      end
      if (mem_wr)
        mem_reg[cm_addr] <= IO_WDATA;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  nmi_gate_a: assert property (NMI |-> !$past(nmi_dis_reg)) else $error("NMI while disabled");
  nmi_raise_a: assert property (!nmi_dis_reg && chk_s2_reg |=> NMI) else $error("NMI missed");
  nmi_reset_a: assert property ($rose(RESETN) |-> nmi_dis_reg && !NMI) else $error("NMI mask not set");
  lo_index_a: assert property (
    IO_WR && int_hit && IO_ADDR == PORT_LO_IDX |=> {nmi_dis_reg, lo_idx_reg} == $past(IO_WDATA))
    else $error("lower index not stored");
  fwd_lo_a: assert property (
    acc && sel_lo && !clk_int |=> (EXT_RTC.rd || EXT_RTC.wr) && !IO_ACK)
    else $error("lower pair not forwarded");
  ext_served_a: assert property (
    IO_RD && sel_ext && clk_int |=> IO_ACK && !EXT_RTC.rd)
    else $error("extended pair not served");
  sram_gate_a: assert property (acc && sel_sr && !sr_open |=> !IO_ACK) else $error("third pair answered");
  sram_open_a: assert property (acc && sel_sr && sr_open |=> IO_ACK) else $error("third pair silent");
  batt_read_a: assert property (
    dat_rd && cm_addr == OFS_BATT_D |=> IO_RDATA[6:0] == 7'h00)
    else $error("status D low bits set");
  flag_clear_a: assert property (
    c_read && !per_tick && !upd_reg |=> flags_reg == 3'h0)
    else $error("flags survived read");
  busy_stop_a: assert property (!run |=> !busy_reg) else $error("busy with divider stopped");
  upd_flag_a: assert property (do_upd |=> ##1 flags_reg[0]) else $error("update flag missing");
  set_hold_a: assert property (
    ctl_b[B_SET] && !mem_wr |=> $stable(mem_reg[OFS_SEC])) else $error("time moved while inhibited");

  // Cover points for the main scenarios
  inhibit_cov_c: cover property (tick && ctl_b[B_SET]);
  fwd_cov_c: cover property (fwd_hit ##1 EXT_RTC.wr);
  alarm_cov_c: cover property (upd_reg && alm_match);
  clear_cov_c: cover property (flags_reg != 3'h0 ##1 c_read);
  sram_cov_c: cover property (dat_wr && sel_sr);
endmodule : crpa_top
`default_nettype wire

//--- test/crpa_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Host processor issuing single-cycle I/O strobes
// ---------------------------------------------------------------
module crpa_host_model (
  input wire logic clk,
  output logic [7:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata
);
  // Idle bus at time zero
  initial
  begin
    io_addr = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  // One strobe per call; idle address and data are inverted so stale values are never trusted
  task automatic cycle(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    #1;
    io_addr = addr;
    io_wr = wr;
    io_rd = !wr;
    io_wdata = wr ? data : ~data;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = ~addr;
    io_wdata = ~io_wdata;
  endtask : cycle
endmodule : crpa_host_model
`default_nettype wire

//--- test/crpa_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module crpa_top_bench
  import crpa_pkg::*;
;
  typedef struct {logic [17:0] val; logic [17:0] mask;} crpa_note_type;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] clk_sel = 8'h04, sram_en = 8'h00, port_en = 8'h00;
  logic chck_n = 1'b1, serr_n = 1'b0, batt = 1'b1;
  logic [7:0] io_addr, io_wdata, io_rdata, idx, d, keep;
  logic io_wr, io_rd, io_ack, nmi;
  logic [17:0] seen;
  logic [15:0] tset [11] = '{16'h0B36, 16'h003B, 16'h023B, 16'h0417, 16'h0701, 16'h0801, 16'h0900,
                             16'h0100, 16'h0300, 16'h7D02, 16'h7E01};
  logic [15:0] bset [6] = '{16'h0059, 16'h0259, 16'h0491, 16'h0731, 16'h0812, 16'h0999};
  crpa_ext_type ext;
  crpa_note_type notes[$];
  crpa_note_type n;
  int err_count = 0, tests_run = 0;

  // ---------------------------------------------------------------
  // Clock, design and host
  // ---------------------------------------------------------------
  always #12.5 sys_clk = ~sys_clk;
  // Short second and periodic base keep the run small
  crpa_top #(.SEC_CYCLES(200), .BUSY_CYCLES(4), .PER_BASE(2)) crpa_top_i (
    .SYS_CLK(sys_clk), .RESETN(resetn), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
    .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IO_ACK(io_ack), .CLOCK_SELECT_REG(clk_sel),
    .SRAM_ENABLE_REG(sram_en), .THIRD_PORT_ENABLE_REG(port_en), .ISA_CHCK_N(chck_n),
    .PCI_SERR_N(serr_n), .BATTERY_GOOD(batt), .NMI(nmi), .EXT_RTC(ext));
  crpa_host_model crpa_host_model_i (.clk(sys_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata));

  // ---------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict;
    if (err_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic step(input int cycles);
    repeat (cycles) @(posedge sys_clk);
    #1;
  endtask : step

  // Kind 00 internal answer, 01 forwarded write, 10 forwarded read, 11 nothing may appear
  task automatic io(input logic wr, input logic [7:0] a, input logic [7:0] dat, input logic [1:0] k,
                    input logic [15:0] v, input logic [15:0] m);
    if (k != 2'b11)
      notes.push_back('{{k, v}, {2'b11, m}});
    crpa_host_model_i.cycle(wr, a, dat);
  endtask : io

  task automatic wr_i(input logic [7:0] a, input logic [7:0] dat);
    io(1'b1, a, dat, 2'b00, 16'h0000, 16'h0000);
  endtask : wr_i

  task automatic rd_i(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    io(1'b0, a, 8'h00, 2'b00, {8'h00, e}, {8'h00, m});
  endtask : rd_i

  task automatic cmos_wr(input logic [7:0] ofs, input logic [7:0] dat);
    wr_i(PORT_EXT_IDX, ofs);
    wr_i(PORT_EXT_DAT, dat);
  endtask : cmos_wr

  task automatic cmos_rd(input logic [7:0] ofs, input logic [7:0] e, input logic [7:0] m);
    wr_i(PORT_EXT_IDX, ofs);
    rd_i(PORT_EXT_DAT, e, m);
  endtask : cmos_rd

  // Every answer takes the oldest note; an answer with no note is a mismatch
  always @(negedge sys_clk)
  begin
    if (io_ack || ext.wr || ext.rd)
    begin
      seen = io_ack ? {2'b00, 8'h00, io_rdata} : ext.wr ? {2'b01, ext.addr, ext.wdata} : {2'b10, ext.addr, 8'h00};
      if (notes.size() == 0)
        check(seen, {2'b11, 16'h0000});
      else
      begin
        n = notes.pop_front();
        check(seen & n.mask, n.val & n.mask);
      end
    end
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(37713));
    step(4);
    resetn = 1'b1;
    step(4);
    check({17'h0, nmi}, 18'h0);
    wr_i(PORT_LO_IDX, 8'h10);
    step(5);
    check({17'h0, nmi}, 18'h1);
    serr_n = 1'b1;
    step(5);
    chck_n = 1'b0;
    step(5);
    check({17'h0, nmi}, 18'h1);
    wr_i(PORT_LO_IDX, 8'h90);
    step(5);
    check({17'h0, nmi}, 18'h0);
    chck_n = 1'b1;
    // Lower pair and extended pair share one array
    for (int i = 0; i < 6; i++)
    begin
      idx = 8'h0E + 8'($urandom % 111);
      d = 8'($urandom);
      wr_i(PORT_LO_IDX, {1'b1, idx[6:0]});
      wr_i(PORT_LO_DAT, d);
      rd_i(PORT_LO_DAT, d, 8'hFF);
      wr_i(PORT_EXT_IDX, idx);
      rd_i(PORT_EXT_IDX, idx, 8'hFF);
      rd_i(PORT_EXT_DAT, d, 8'hFF);
      idx = 8'hC0 + 8'($urandom % 64);
      cmos_wr(idx, ~d);
      cmos_rd(idx, ~d, 8'hFF);
    end
    rd_i(PORT_LO_IDX, 8'h00, 8'hFF);
    // Clock off: 70-73 go outside, third pair only with both enables
    clk_sel = 8'h00;
    for (int a = 8'h70; a <= 8'h73; a++)
    begin
      d = 8'($urandom);
      io(1'b1, 8'(a), d, 2'b01, {8'(a), d}, 16'hFFFF);
      io(1'b0, 8'(a), 8'h00, 2'b10, {8'(a), 8'h00}, 16'hFF00);
    end
    for (int c = 0; c < 4; c++)
    begin
      sram_en = {6'h00, c[0], 1'b0};
      port_en = {4'h0, c[1], 3'h0};
      idx = 8'h80 + 8'(c);
      keep = 8'($urandom) | 8'h01;
      io(1'b1, PORT_SR_IDX, idx, (c == 3) ? 2'b00 : 2'b11, 16'h0000, 16'h0000);
      io(0, PORT_SR_IDX, 0, (c == 3) ? 2'b00 : 2'b11, {8'h00, idx}, 16'h00FF);
      io(1'b1, PORT_SR_DAT, keep, (c == 3) ? 2'b00 : 2'b11, 16'h0000, 16'h0000);
      io(0, PORT_SR_DAT, 0, (c == 3) ? 2'b00 : 2'b11, {8'h00, keep}, 16'h00FF);
    end
    clk_sel = 8'h04;
    for (int c = 0; c < 4; c++)
      cmos_rd(8'h80 + 8'(c), (c == 3) ? keep : 8'h00, 8'hFF);
    // Status and control registers
    cmos_rd(OFS_BATT_D, 8'h80, 8'hFF);
    batt = 1'b0;
    cmos_wr(OFS_BATT_D, 8'hFF);
    cmos_rd(OFS_BATT_D, 8'h00, 8'hFF);
    cmos_rd(OFS_FLAGS_C, 8'h00, 8'hFF);
    d = 8'($urandom);
    cmos_wr(OFS_CTL_B, d);
    cmos_rd(OFS_CTL_B, d, 8'hFF);
    cmos_wr(OFS_CTL_A, 8'h8F);
    cmos_rd(OFS_CTL_A, 8'h0F, 8'hFF);
    // 23:59:59 binary 24-hour rolls into the next day and hits the alarm
    for (int i = 0; i < 11; i++)
      cmos_wr(tset[i][15:8], tset[i][7:0]);
    cmos_wr(OFS_CTL_A, 8'h20);
    step(220);
    cmos_rd(OFS_SEC, 8'h00, 8'hFF);
    cmos_rd(OFS_MIN, 8'h00, 8'hFF);
    cmos_rd(OFS_HOUR, 8'h00, 8'hFF);
    cmos_rd(OFS_DATE, 8'h02, 8'hFF);
    cmos_rd(OFS_FLAGS_C, 8'hB0, 8'hFF);
    cmos_rd(OFS_FLAGS_C, 8'h00, 8'hFF);
    cmos_wr(OFS_CTL_A, 8'h21);
    step(20);
    cmos_rd(OFS_FLAGS_C, 8'h40, 8'h40);
    // BCD 12-hour 11:59:59 pm, 31 Dec 99: held by the inhibit bit, then released
    cmos_wr(OFS_CTL_A, 8'h00);
    cmos_wr(OFS_CTL_B, 8'h80);
    for (int i = 0; i < 6; i++)
      cmos_wr(bset[i][15:8], bset[i][7:0]);
    cmos_wr(OFS_CTL_A, 8'h20);
    step(220);
    cmos_rd(OFS_SEC, 8'h59, 8'hFF);
    cmos_wr(OFS_CTL_B, 8'h00);
    step(200);
    cmos_rd(OFS_SEC, 8'h00, 8'hFF);
    cmos_rd(OFS_HOUR, 8'h12, 8'hFF);
    cmos_rd(OFS_DATE, 8'h01, 8'hFF);
    cmos_rd(OFS_MONTH, 8'h01, 8'hFF);
    cmos_rd(OFS_YEAR, 8'h00, 8'hFF);
    // Mid-run reset brings the NMI mask back and clears the array
    chck_n = 1'b0;
    wr_i(PORT_LO_IDX, 8'h00);
    step(5);
    check({17'h0, nmi}, 18'h1);
    resetn = 1'b0;
    step(4);
    resetn = 1'b1;
    step(4);
    check({17'h0, nmi}, 18'h0);
    cmos_rd(8'h83, 8'h00, 8'hFF);
    step(4);
    check(18'(notes.size()), 18'h0);
    print_verdict();
  end
endmodule : crpa_top_bench
`default_nettype wire
